/* File: inc/relay_pkg.sv */
// Shared constants for the set/reset/toggle relay block.
package relay_pkg;
	typedef enum logic {
		reset_dominant,
		set_dominant
	} priority_t;

	typedef enum logic {
		variant_latch,
		variant_pulse
	} variant_t;

	localparam logic OUT_RESET_VAL = 1'b0;
	localparam logic RETAIN_OFF = 1'b0;
	localparam int SYNC_STAGES = 2;
endpackage

/* File: hw/sync2.sv */
// Two-stage synchroniser for a single level.
`timescale 1ns/1ps
`default_nettype none
module sync2 (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_int_n,
	// Data
	input wire logic d,
	output logic q
);
	logic meta_ff;
	logic q_ff;
	logic nxt_meta;
	logic nxt_q;

	// The first stage feeds only the second stage.
	always_comb begin
		nxt_meta = d;
		nxt_q = meta_ff;
	end

	always_ff @(posedge clk_sys or negedge rst_int_n) begin
		if (!rst_int_n) begin
			meta_ff <= 1'b0;
			q_ff <= 1'b0;
		end else begin
			meta_ff <= nxt_meta;
			q_ff <= nxt_q;
		end
	end

	assign q = q_ff;
endmodule
`default_nettype wire

/* File: hw/relay_core.sv */
// Bistable relay element: plain set/reset latch or trigger-toggled pulse relay.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Latch: with set and reset both low, the output holds its value.
// - Latch: set and reset together drive the output low.
// - Latch: set alone drives high, reset alone drives low.
// - Latch with retention restores the last output after power loss.
// - Pulse relay: each trigger rising edge inverts output when set, reset low.
// - Pulse relay: trigger ignored while set or reset is high.
// - Pulse relay: set forces the output high.
// - Pulse relay: reset forces the output low.
// - Pulse relay offers reset-dominant or set-dominant priority selection.
// - Pulse relay with retention keeps its output across power loss.
// - Pulse relay: set-dominant gives high on both inputs; reset-dominant gives low.
// - Without retention the pulse relay comes up with output cleared.
module relay_core
	import relay_pkg::*;
(
	// Clock and power-up reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Configuration
	input wire logic variant_pulse_sel,
	input wire logic prio_set_dominant,
	input wire logic retain_en,
	// Retained state presented by the backup store at power-up
	input wire logic retained_q,
	// Relay inputs from surrounding logic
	input wire logic set_in,
	input wire logic reset_in,
	input wire logic trig_in,
	// Output
	output logic q
);
	localparam logic [1:0] BOOT_CNT_RST = 2'(SYNC_STAGES);

	logic rst_meta_ff;
	logic rst_int_ff;
	logic nxt_rst_meta;
	logic nxt_rst_int;
	logic rst_int_n;
	logic set_s;
	logic reset_s;
	logic trig_s;
	logic cfg_pulse;
	logic cfg_setdom;
	logic cfg_retain;
	logic retained_s;
	logic trig_prev_ff;
	logic q_ff;
	logic load_pend_ff;
	logic [1:0] boot_cnt_ff;
	logic nxt_trig_prev;
	logic nxt_q;
	logic nxt_load_pend;
	logic [1:0] nxt_boot_cnt;
	logic trig_rise;
	logic boot_ready;
	logic load_now;
	logic latch_q;
	logic pulse_q;
	variant_t variant;
	priority_t prio;

	// Reset is released through two flip-flops.
	always_comb begin
		nxt_rst_meta = 1'b1;
		nxt_rst_int = rst_meta_ff;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_ff <= 1'b0;
			rst_int_ff <= 1'b0;
		end else begin
			rst_meta_ff <= nxt_rst_meta;
			rst_int_ff <= nxt_rst_int;
		end
	end
	assign rst_int_n = rst_int_ff;

	// Every input comes from outside this clock domain.
	sync2 u_sync_set (
		.clk_sys(clk_sys),
		.rst_int_n(rst_int_n),
		.d(set_in),
		.q(set_s)
	);
	sync2 u_sync_rst (
		.clk_sys(clk_sys),
		.rst_int_n(rst_int_n),
		.d(reset_in),
		.q(reset_s)
	);
	sync2 u_sync_trg (
		.clk_sys(clk_sys),
		.rst_int_n(rst_int_n),
		.d(trig_in),
		.q(trig_s)
	);
	sync2 u_sync_var (
		.clk_sys(clk_sys),
		.rst_int_n(rst_int_n),
		.d(variant_pulse_sel),
		.q(cfg_pulse)
	);
	sync2 u_sync_pri (
		.clk_sys(clk_sys),
		.rst_int_n(rst_int_n),
		.d(prio_set_dominant),
		.q(cfg_setdom)
	);
	sync2 u_sync_ret (
		.clk_sys(clk_sys),
		.rst_int_n(rst_int_n),
		.d(retain_en),
		.q(cfg_retain)
	);
	sync2 u_sync_rq (
		.clk_sys(clk_sys),
		.rst_int_n(rst_int_n),
		.d(retained_q),
		.q(retained_s)
	);

	assign variant = cfg_pulse ? variant_pulse : variant_latch;
	assign prio = cfg_setdom ? set_dominant : reset_dominant;

	// The synchronisers leave reset holding zeros, so the restore waits until the
	// straps and the backed-up value have crossed both stages; earlier inputs are lost.
	assign boot_ready = (boot_cnt_ff == 2'h0);
	assign load_now = load_pend_ff & boot_ready;

	always_comb begin
		nxt_boot_cnt = boot_cnt_ff;
		nxt_load_pend = load_pend_ff;
		if (!boot_ready) begin
			nxt_boot_cnt = boot_cnt_ff - 2'h1;
		end
		if (load_now) begin
			nxt_load_pend = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_int_n) begin
		if (!rst_int_n) begin
			boot_cnt_ff <= BOOT_CNT_RST;
			load_pend_ff <= 1'b1;
		end else begin
			boot_cnt_ff <= nxt_boot_cnt;
			load_pend_ff <= nxt_load_pend;
		end
	end

	assign trig_rise = trig_s & ~trig_prev_ff;

	always_comb begin
		nxt_trig_prev = trig_s;
	end

	always_ff @(posedge clk_sys or negedge rst_int_n) begin
		if (!rst_int_n) begin
			trig_prev_ff <= 1'b1;
		end else begin
			trig_prev_ff <= nxt_trig_prev;
		end
	end

	// The plain latch lets reset win whatever the priority strap says.
	always_comb begin
		latch_q = q_ff;
		if (reset_s) begin
			latch_q = 1'b0;
		end else if (set_s) begin
			latch_q = 1'b1;
		end
	end

	// In the pulse relay set and reset mask the trigger completely.
	always_comb begin
		pulse_q = q_ff;
		if (set_s && reset_s) begin
			pulse_q = (prio == set_dominant);
		end else if (set_s) begin
			pulse_q = 1'b1;
		end else if (reset_s) begin
			pulse_q = 1'b0;
		end else if (trig_rise) begin
			pulse_q = ~q_ff;
		end
	end

	always_comb begin
		nxt_q = q_ff;
		if (load_now) begin
			// Straps settle through the synchronisers before the restore is taken.
			if (cfg_retain) begin
				nxt_q = retained_s;
			end else begin
				nxt_q = OUT_RESET_VAL;
			end
		end else if (!load_pend_ff) begin
			case (variant)
				variant_latch: begin
					nxt_q = latch_q;
				end
				variant_pulse: begin
					nxt_q = pulse_q;
				end
				default: begin
					nxt_q = q_ff;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_int_n) begin
		if (!rst_int_n) begin
			q_ff <= OUT_RESET_VAL;
		end else begin
			q_ff <= nxt_q;
		end
	end

	assign q = q_ff;
endmodule
`default_nettype wire

/* File: verification/relay_src.sv */
// Model of the program logic that drives the relay inputs.
`timescale 1ns/1ps
`default_nettype none
module relay_src (
	// Clock, command in, relay inputs out
	input wire logic clk_sys,
	input wire logic [2:0] cmd,
	output logic set_in,
	output logic reset_in,
	output logic trig_in
);
	always_ff @(posedge clk_sys) {trig_in, reset_in, set_in}<=cmd;
endmodule
`default_nettype wire

/* File: verification/relay_monitor.sv */
// Port checks of the relay element.
`timescale 1ns/1ps
`default_nettype none
module relay_monitor (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Straps
	input wire logic variant_pulse_sel,
	input wire logic prio_set_dominant,
	input wire logic retain_en,
	input wire logic retained_q,
	// Relay inputs and output
	input wire logic set_in,
	input wire logic reset_in,
	input wire logic trig_in,
	input wire logic q
);
	logic [11:0] h_ff;
	logic [5:0] up_ff;
	wire logic s=h_ff[6], r=h_ff[7], e=h_ff[8]&~h_ff[11], p=variant_pulse_sel, u=up_ff[5];
	wire logic d=prio_set_dominant, b=up_ff[4];
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// Inputs reach q three edges late; the restore shows on the edge where b rises,
	// so the input checks start one edge later.
	always_ff @(posedge clk_sys) h_ff<={h_ff[8:0], trig_in, reset_in, set_in};
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			up_ff <= 6'h00;
		end else begin
			up_ff <= {up_ff[4:0], 1'b1};
		end
	end
	sequence calm_s; u&~s&~r; endsequence
	sequence flip_s; calm_s ##0 p&e; endsequence
	AST_HOLD: assert property (calm_s ##0 !(p&e) |-> $stable(q)) else $error("hold");
	AST_FLIP: assert property (flip_s |-> q!=$past(q)) else $error("flip");
	AST_LBOTH: assert property (u&~p&s&r |-> !q) else $error("lboth");
	AST_LSET: assert property (u&~p&s&~r |-> q) else $error("lset");
	AST_LRST: assert property (u&~p&r&~s |-> !q) else $error("lrst");
	AST_PSET: assert property (u&p&s&(~r|d) |-> q) else $error("pset");
	AST_PRST: assert property (u&p&r&~(s&d) |-> !q) else $error("prst");
	AST_BOOT: assert property ($rose(b) |-> q==(retain_en&retained_q))
		else $error("boot");
endmodule
bind relay_core relay_monitor mon (
	.clk_sys(clk_sys),
	.rst_n(rst_n),
	.variant_pulse_sel(variant_pulse_sel),
	.prio_set_dominant(prio_set_dominant),
	.retain_en(retain_en),
	.retained_q(retained_q),
	.set_in(set_in),
	.reset_in(reset_in),
	.trig_in(trig_in),
	.q(q)
);
`default_nettype wire

/* File: verification/testbench.sv */
// Self-checking bench of the relay element.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g,e) begin comparisons++; if ((g)!==(e)) begin fail_count++; \
	$display("MISMATCH %0t %h %h", $time, g, e); end end
module testbench;
	logic clk_sys=0, rst_n=0, q;
	wire logic set_in, reset_in, trig_in;
	logic [3:0] m=4'hf;
	logic [2:0] cmd=3'h0;
	int fail_count=0, comparisons=0;
	// Row: pulse, set wins, retain, stored q, trigger, reset, set, expected q.
	logic [7:0] rows[24]='{8'h03,8'h01,8'h06,8'h03,8'h04,8'h89,8'h81,8'h88,8'h83,8'h8b,
		8'h89,8'h84,8'h8c,8'h88,8'h86,8'hc7,8'hc8,8'h31,8'hb1,8'h90,8'h43,8'h46,8'h48,8'h43};
	always #12.5 clk_sys=~clk_sys;
	relay_src src (.*);
	relay_core DUT (.variant_pulse_sel(m[3]), .prio_set_dominant(m[2]), .retain_en(m[1]),
		.retained_q(m[0]), .*);
	task automatic go(int n);
		repeat (n) @(posedge clk_sys);
		#2;
	endtask
	task automatic results;
		$display("checks %0d errors %0d", comparisons, fail_count);
		if (fail_count==0 && comparisons>0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		foreach (rows[i]) begin
			// Straps move only under reset, since the element reads retain_en and retained_q once at start-up.
			if (rows[i][7:4]!=m) begin
				{rst_n, cmd, m}={4'h0, rows[i][7:4]};
				go(12);
				rst_n=1;
				go(8);
			end
			cmd=rows[i][3:1];
			go(6);
			`CHK(q, rows[i][0])
		end
		// Reset clears a set output at once, and a trigger held high through reset is no edge.
		{rst_n, cmd, m}={1'b0, 3'h4, 4'h8};
		#1;
		`CHK(q, 1'b0)
		go(12);
		rst_n=1;
		go(10);
		`CHK(q, 1'b0)
		// A trigger pulse of a single cycle toggles exactly once.
		cmd=3'h0;
		go(1);
		cmd=3'h4;
		go(1);
		cmd=3'h0;
		go(6);
		`CHK(q, 1'b1)
		results();
	end
	initial begin
		go(900);
		fail_count++;
		results();
	end
endmodule
`default_nettype wire
